// File: core/startup_gate_pkg.sv
// Constants and types for the start-up gating logic
package startup_gate_pkg;

  localparam int unsigned CFG_SEL_W = 5;

  // Function assigned to the gating pin by the configuration
  localparam logic FUNC_POWER_DOWN = 1'h0;
  localparam logic FUNC_RESTART    = 1'h1;

  localparam logic [CFG_SEL_W-1:0] CFG_SEL_RESET = 5'h00;

  typedef enum logic [2:0] {
    ST_HALTED,
    ST_LOAD,
    ST_RUN,
    ST_LOW_POWER,
    ST_RESTART
  } gate_state_t;

endpackage

// File: core/power_good_startup_gate.sv
// Start-up gate driven by the supply-valid / low-power request pin
`timescale 1ns/1ps
`default_nettype none

// Operation
// - While the gating pin is low the start-up sequence stays halted and continues only when it goes high.
// - The pin may be low from the first moment after reset and the gate then stays halted throughout.
// - In power-down mode the first rise loads a new configuration chosen by the select pins.
// - In power-down mode each later rise returns to the configuration already loaded.
// - In power-down mode, once a configuration is loaded, a low pin enters or holds a low-power state with the synth loop off.
// - Leaving power-down resumes exactly the operating state held before it.
// - In restart mode a low pin resets the device to repeat the whole power-up sequence.
// - In restart mode a rise loads a configuration anew, which may differ from before.
// - The configuration gives the pin either the power-down or the restart function, never both.
module power_good_startup_gate
  import startup_gate_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                 i_core_clk,
  input  wire logic                 i_arst_n,
  input  wire logic                 i_clk_en,
  // Gating pin
  input  wire logic                 i_supply_valid_in,
  // Configuration selection pins and load handshake
  input  wire logic [CFG_SEL_W-1:0] i_cfg_sel_pins,
  input  wire logic                 i_cfg_load_done,
  input  wire logic                 i_pin_func_restart,
  // Sequencer control
  output logic                      o_seq_run,
  output logic                      o_cfg_load_req,
  output logic [CFG_SEL_W-1:0]      o_cfg_sel,
  output logic                      o_low_power,
  output logic                      o_main_synth_loop_en,
  output logic                      o_core_reset_n,
  output logic                      o_pin_func
);

  // ----------------------------------------------------------------
  // Pin synchroniser and edge detect
  // ----------------------------------------------------------------
  logic                 sync1_reg, sync2_reg, sync3_reg;
  logic                 sync1_next, sync2_next, sync3_next;
  logic [CFG_SEL_W-1:0] sel_sync1_reg, sel_sync2_reg;
  logic [CFG_SEL_W-1:0] sel_sync1_next, sel_sync2_next;
  logic                 pin_rise, pin_fall;

  // Select pins are board pins too: same two-stage path as the gate pin
  always_comb begin
    sync1_next     = sync1_reg;
    sync2_next     = sync2_reg;
    sync3_next     = sync3_reg;
    sel_sync1_next = sel_sync1_reg;
    sel_sync2_next = sel_sync2_reg;
    if (i_clk_en) begin
      sync1_next     = i_supply_valid_in;
      sync2_next     = sync1_reg;
      sync3_next     = sync2_reg;
      sel_sync1_next = i_cfg_sel_pins;
      sel_sync2_next = sel_sync1_reg;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1_reg     <= 1'h0;
      sync2_reg     <= 1'h0;
      sync3_reg     <= 1'h0;
      sel_sync1_reg <= CFG_SEL_RESET;
      sel_sync2_reg <= CFG_SEL_RESET;
    end else begin
      sync1_reg     <= sync1_next;
      sync2_reg     <= sync2_next;
      sync3_reg     <= sync3_next;
      sel_sync1_reg <= sel_sync1_next;
      sel_sync2_reg <= sel_sync2_next;
    end
  end

  assign pin_rise = sync2_reg & ~sync3_reg;
  assign pin_fall = ~sync2_reg & sync3_reg;

  // ----------------------------------------------------------------
  // Gate state machine
  // ----------------------------------------------------------------
  gate_state_t            state_reg, state_next;
  logic                   loaded_reg, loaded_next;
  logic                   func_reg, func_next;
  logic [CFG_SEL_W-1:0]   sel_reg, sel_next;

  always_comb begin
    state_next  = state_reg;
    loaded_next = loaded_reg;
    func_next   = func_reg;
    sel_next    = sel_reg;
    if (i_clk_en) begin
      case (state_reg)
        ST_HALTED: begin
          // Level, so a rise landing in a one-cycle state is not lost
          if (sync2_reg) begin
            if (loaded_reg && func_reg == FUNC_POWER_DOWN) begin
              state_next = ST_RUN;
            end else begin
              sel_next   = sel_sync2_reg;
              state_next = ST_LOAD;
            end
          end
        end
        ST_LOAD: begin
          if (!sync2_reg) begin
            state_next = ST_HALTED;
          end else if (i_cfg_load_done) begin
            loaded_next = 1'h1;
            func_next   = i_pin_func_restart;
            state_next  = ST_RUN;
          end
        end
        ST_RUN: begin
          if (pin_fall) begin
            state_next = (func_reg == FUNC_RESTART) ? ST_RESTART : ST_LOW_POWER;
          end
        end
        ST_LOW_POWER: begin
          state_next = ST_HALTED;
        end
        ST_RESTART: begin
          loaded_next = 1'h0;
          func_next   = FUNC_POWER_DOWN;
          sel_next    = CFG_SEL_RESET;
          state_next  = ST_HALTED;
        end
        default: state_next = ST_HALTED;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg  <= ST_HALTED;
      loaded_reg <= 1'h0;
      func_reg   <= FUNC_POWER_DOWN;
      sel_reg    <= CFG_SEL_RESET;
    end else begin
      state_reg  <= state_next;
      loaded_reg <= loaded_next;
      func_reg   <= func_next;
      sel_reg    <= sel_next;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic run_reg, load_reg, lp_reg, synth_reg, crst_n_reg;
  logic run_next, load_next, lp_next, synth_next, crst_n_next;

  always_comb begin
    run_next    = (state_next == ST_RUN);
    load_next   = (state_next == ST_LOAD);
    lp_next     = loaded_next && (func_next == FUNC_POWER_DOWN)
                  && (state_next == ST_HALTED || state_next == ST_LOW_POWER);
    synth_next  = (state_next == ST_RUN);
    crst_n_next = (state_next != ST_RESTART) && loaded_next;
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      run_reg    <= 1'h0;
      load_reg   <= 1'h0;
      lp_reg     <= 1'h0;
      synth_reg  <= 1'h0;
      crst_n_reg <= 1'h0;
    end else begin
      run_reg    <= run_next;
      load_reg   <= load_next;
      lp_reg     <= lp_next;
      synth_reg  <= synth_next;
      crst_n_reg <= crst_n_next;
    end
  end

  assign o_seq_run            = run_reg;
  assign o_cfg_load_req       = load_reg;
  assign o_cfg_sel            = sel_reg;
  assign o_low_power          = lp_reg;
  assign o_main_synth_loop_en = synth_reg;
  assign o_core_reset_n       = crst_n_reg;
  assign o_pin_func           = func_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  halted_low_a: assert property (i_clk_en && !sync2_reg |-> ##1 !o_seq_run)
    else $error("sequencer runs while pin low");
  startup_hold_a: assert property (i_clk_en && !loaded_reg && !sync2_reg
                                   |-> ##1 !o_seq_run && !o_cfg_load_req)
    else $error("start-up left halted state with pin low");
  first_load_a: assert property (i_clk_en && state_reg == ST_HALTED && pin_rise && !loaded_reg
                                 |-> ##1 o_cfg_load_req && o_cfg_sel == $past(sel_sync2_reg))
    else $error("first rise did not request load");
  resume_a: assert property (i_clk_en && state_reg == ST_HALTED && pin_rise && loaded_reg
                             && func_reg == FUNC_POWER_DOWN |-> ##1 o_seq_run && !o_cfg_load_req)
    else $error("power-down return fetched new configuration");
  keep_sel_a: assert property (func_reg == FUNC_POWER_DOWN && loaded_reg |-> ##1 $stable(o_cfg_sel))
    else $error("configuration changed across power-down");
  low_power_a: assert property (i_clk_en && state_reg == ST_LOW_POWER
                                |-> ##1 o_low_power && !o_main_synth_loop_en)
    else $error("low-power state not entered");
  restart_a: assert property (i_clk_en && state_reg == ST_RUN && pin_fall && func_reg == FUNC_RESTART
                              |-> ##1 !o_core_reset_n ##1 !o_core_reset_n && (!loaded_reg || !$past(i_clk_en)))
    else $error("restart did not reset");
  reload_a: assert property (i_clk_en && state_reg == ST_HALTED && pin_rise && !loaded_reg
                             |-> ##1 state_reg == ST_LOAD)
    else $error("restart return did not reload");
  sync_edge_a: assert property ($rose(sync2_reg) |-> $past(sync1_reg) && pin_rise)
    else $error("edge not from synchronised pin");
  one_func_a: assert property (o_low_power |-> o_pin_func == FUNC_POWER_DOWN)
    else $error("low power under restart function");

  run_c:     cover property (o_seq_run);
  lowpwr_c:  cover property (o_low_power ##[1:50] o_seq_run);
  restart_c: cover property (!o_core_reset_n && func_reg == FUNC_RESTART);

endmodule
`default_nettype wire

// File: test/supervisor_model.sv
// Model of the external supervisor and configuration store
`timescale 1ns/1ps
`default_nettype none
module supervisor_model (
  // Control from bench
  input  wire logic       i_clk,
  input  wire logic       i_rails_ok,
  input  wire logic       i_want_high,
  input  wire logic       i_func,
  input  wire logic [3:0] i_dly,
  // Gate side
  input  wire logic       i_req,
  output logic            o_pin,
  output logic            o_done,
  output logic            o_func
);
  int hold_cnt = 0;
  int wait_cnt = 0;
  always @(posedge i_clk) begin
    hold_cnt <= i_rails_ok ? hold_cnt + 1 : 0;
    wait_cnt <= i_req ? wait_cnt + 1 : 0;
  end
  // Pin rises only once rails are valid and held
  assign o_pin  = i_want_high && i_rails_ok && hold_cnt > 6;
  assign o_done = i_req && wait_cnt >= i_dly;
  // Function bit is garbage outside the done strobe
  assign o_func = o_done ? i_func : ~i_func;
endmodule
`default_nettype wire

// File: test/test_power_good_startup_gate.sv
// Self-checking bench for the start-up gate
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module test_power_good_startup_gate;
  import startup_gate_pkg::*;
  logic clk = 0, arst_n = 0, clk_en = 1, rails = 0, want = 0, func = 0;
  logic [3:0] dly = 1;
  logic [CFG_SEL_W-1:0] pins = '0, sel;
  logic pin, done, pfunc, run, req, lp, synth, rst_n, pf;
  logic [2:0] ob;
  int n_errors = 0, checks_done = 0, m_sel = 0;
  logic [31:0] rs = 42933;
  assign ob = {lp, run, req};
  initial forever #2 clk = ~clk;
  supervisor_model PM (.i_clk(clk), .i_rails_ok(rails), .i_want_high(want), .i_func(func),
    .i_dly(dly), .i_req(req), .o_pin(pin), .o_done(done), .o_func(pfunc));
  power_good_startup_gate DUT (.i_core_clk(clk), .i_arst_n(arst_n), .i_clk_en(clk_en),
    .i_supply_valid_in(pin), .i_cfg_sel_pins(pins), .i_cfg_load_done(done),
    .i_pin_func_restart(pfunc), .o_seq_run(run), .o_cfg_load_req(req), .o_cfg_sel(sel),
    .o_low_power(lp), .o_main_synth_loop_en(synth), .o_core_reset_n(rst_n), .o_pin_func(pf));
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait for one output to reach a level
  task automatic wt(input int s, input logic v);
    int k;
    for (k = 0; k < 60 && ob[s] !== v; k++) cyc(1);
    if (k == 60) begin
      n_errors++;
      give_verdict();
    end
  endtask
  task automatic ex(input logic r, input logic l, input logic n, input logic f);
    `CHK(run, r)
    `CHK(synth, r)
    `CHK(lp, l)
    `CHK(rst_n, n)
    `CHK(pf, f)
    if (n) `CHK(sel, CFG_SEL_W'(m_sel))
  endtask
  task automatic do_load(input logic f);
    @(posedge clk);
    func <= f;
    dly <= 4'(xs() % 8 + 1);
    pins <= CFG_SEL_W'(xs());
    want <= 1;
    cyc(1);
    m_sel = pins;
    wt(0, 1);
    `CHK(sel, CFG_SEL_W'(m_sel))
    wt(1, 1);
    ex(1, 0, 1, f);
  endtask
  task automatic set_pin(input logic v);
    @(posedge clk);
    want <= v;
    pins <= CFG_SEL_W'(xs());
  endtask
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1;
    want   <= 1;
    cyc(20);
    ex(0, 0, 0, 0);
    @(posedge clk);
    clk_en <= 0;
    rails  <= 1;
    cyc(30);
    `CHK(req, 1'h0)
    @(posedge clk);
    clk_en <= 1;
    want   <= 0;
    $display("test halt end");
    do_load(0);
    set_pin(0);
    wt(2, 1);
    ex(0, 1, 1, 0);
    set_pin(1);
    wt(1, 1);
    ex(1, 0, 1, 0);
    $display("test power-down end");
    @(posedge clk);
    arst_n <= 0;
    want   <= 0;
    repeat (8) @(posedge clk);
    arst_n <= 1;
    cyc(2);
    ex(0, 0, 0, 0);
    do_load(1);
    set_pin(0);
    wt(1, 0);
    ex(0, 0, 0, 1);
    do_load(1);
    $display("test restart end");
    give_verdict();
  end
endmodule
`default_nettype wire
